// *** pkg/ccw_pkg.sv ***
package ccw_pkg;
  // bus and register geometry
  localparam int CCW_DATA_W = 16;
  localparam int CCW_BE_W = 2;
  localparam int CCW_ADDR_W = 4;
  localparam logic [CCW_ADDR_W-1:0] CCW_CTRL_OFFSET = 4'h0;

  // control word: reset image and the bits that software may write
  localparam logic [CCW_DATA_W-1:0] CCW_CTRL_RESET = 16'h0020;
  localparam logic [CCW_DATA_W-1:0] CCW_CTRL_RW_MASK = 16'h10f7;
  localparam logic [2:0] CCW_UNUSED_READ = 3'h0;

  // field positions in the control word
  localparam int CCW_UNUSED_LSB = 13;
  localparam int CCW_BIT_SIGN = 12;
  localparam int CCW_BIT_EXIT = 11;
  localparam int CCW_LVL_LSB = 8;
  localparam int CCW_BIT_CLAMP_A = 7;
  localparam int CCW_BIT_CLAMP_B = 6;
  localparam int CCW_BIT_STORE = 5;
  localparam int CCW_BIT_CLAMP_MODE = 4;
  localparam int CCW_BIT_PRIO_TOP = 3;
  localparam int CCW_BIT_PROG_VIEW = 2;
  localparam int CCW_BIT_ROUND = 1;
  localparam int CCW_BIT_INT_MODE = 0;

  // loop depth and priority field widths
  localparam int CCW_LVL_W = 3;
  localparam int CCW_PRIO_LSB = 5;
  localparam int CCW_PRIO_W = 3;

  // accumulator arithmetic widths
  localparam int CCW_SUM_W = 41;
  localparam int CCW_ACC_W = 40;
  localparam int CCW_NARROW_W = 32;
  localparam int CCW_STORE_LSB = 16;
  localparam logic [CCW_ACC_W-1:0] CCW_ACC_NARROW_MAX = 40'h007fffffff;
  localparam logic [CCW_DATA_W-1:0] CCW_STORE_MIN = 16'h8000;

  // slave handshake states
  typedef enum logic {CCW_BUS_IDLE, CCW_BUS_ANSWER} ccw_bus_state_type;
endpackage

// *** rtl/ccw_clamp.sv ***
module ccw_clamp #(
  parameter int IN_W = 41,
  parameter int WIDE_W = 40,
  parameter int NARROW_W = 32,
  parameter int OUT_W = 40,
  parameter int OUT_LSB = 0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [IN_W-1:0] value_i,
  input wire logic enable_i,
  input wire logic wide_i,
  output logic [OUT_W-1:0] value_o
);
  import ccw_pkg::*;

  logic [IN_W-1:0] clamped;
  logic [OUT_W-1:0] out_next;
  logic [OUT_W-1:0] out_reg;

  // limit a signed value to the range of a w-bit signed number
  function automatic logic [IN_W-1:0] clamp_to(input logic [IN_W-1:0] v, input int w);
    logic [IN_W-1:0] lim;
    logic ovf;
    ovf = 1'b0;
    lim = '0;
    for (int i = 0; i < IN_W; i++) begin
      if (i >= w - 1 && v[i] != v[IN_W-1]) ovf = 1'b1;
      lim[i] = (i < w - 1) ? ~v[IN_W-1] : v[IN_W-1];
    end
    return ovf ? lim : v;
  endfunction

  // clamp only when enabled, otherwise the raw bits pass and wrap
  always_comb begin
    clamped = value_i;
    if (enable_i) begin
      clamped = wide_i ? clamp_to(value_i, WIDE_W) : clamp_to(value_i, NARROW_W);
    end
    out_next = clamped[OUT_LSB +: OUT_W];
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) out_reg <= '0;
    else out_reg <= out_next;
  end

  assign value_o = out_reg;
endmodule

// *** rtl/ccw_loop_track.sv ***
module ccw_loop_track #(
  parameter int LVL_W = 3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic iter_end_i,
  input wire logic done_i,
  input wire logic exit_req_i,
  output logic [LVL_W-1:0] depth_o,
  output logic exit_o
);
  import ccw_pkg::*;

  logic [LVL_W-1:0] depth_reg;
  logic [LVL_W-1:0] depth_next;
  logic exit_reg;
  logic exit_next;
  logic inc;
  logic dec;

  // an early exit and a natural finish in one cycle retire one loop only
  always_comb begin
    exit_next = exit_req_i && iter_end_i && (depth_reg != '0);
    dec = exit_next || (done_i && (depth_reg != '0));
    inc = start_i && (depth_reg != '1); // depth saturates at all ones
    case ({inc, dec})
      2'b10: depth_next = depth_reg + LVL_W'(1);
      2'b01: depth_next = depth_reg - LVL_W'(1);
      default: depth_next = depth_reg;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      depth_reg <= '0;
      exit_reg <= 1'b0;
    end else begin
      depth_reg <= depth_next;
      exit_reg <= exit_next;
    end
  end

  assign depth_o = depth_reg;
  assign exit_o = exit_reg;
endmodule

// *** rtl/ccw_core_ctrl.sv ***
// Function
// - writing one to the exit bit ends the running loop after this iteration
// - a read-only three-bit field reports how many nested loops are active
// - full cpu priority level is the top bit joined above status bits 7:5
// - accumulator A clamp enable bit; set clamps overflowing results, clear wraps
// - store clamp enable bit governs clamping of engine writes into data space
// - writable select bit switches the multiplier between integer and fractional
module ccw_core_ctrl (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ccw_pkg::CCW_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ccw_pkg::CCW_DATA_W-1:0] avs_writedata_i,
  input wire logic [ccw_pkg::CCW_BE_W-1:0] avs_byteenable_i,
  output logic [ccw_pkg::CCW_DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic loop_start_i,
  input wire logic iteration_end_i,
  input wire logic loop_done_i,
  output logic loop_exit_o,
  output logic [ccw_pkg::CCW_LVL_W-1:0] loop_nest_level_o,
  input wire logic priority_top_set_i,
  input wire logic [ccw_pkg::CCW_DATA_W-1:0] cpu_status_word_i,
  output logic [ccw_pkg::CCW_PRIO_W:0] cpu_priority_level_o,
  input wire logic [ccw_pkg::CCW_SUM_W-1:0] acc_a_sum_i,
  output logic [ccw_pkg::CCW_ACC_W-1:0] acc_a_o,
  input wire logic [ccw_pkg::CCW_SUM_W-1:0] acc_b_sum_i,
  output logic [ccw_pkg::CCW_ACC_W-1:0] acc_b_o,
  input wire logic [ccw_pkg::CCW_ACC_W-1:0] store_acc_i,
  output logic [ccw_pkg::CCW_DATA_W-1:0] store_word_o,
  output logic multiply_sign_select_o,
  output logic int_mode_select_o,
  output logic round_mode_select_o,
  output logic program_view_enable_o
);
  import ccw_pkg::*;

  ccw_bus_state_type state_reg;
  ccw_bus_state_type state_next;
  logic wait_reg;
  logic wait_next;
  logic [CCW_DATA_W-1:0] rdata_reg;
  logic [CCW_DATA_W-1:0] rdata_next;
  logic [CCW_DATA_W-1:0] ctrl_reg;
  logic [CCW_DATA_W-1:0] ctrl_next;
  logic exit_req_reg;
  logic exit_req_next;
  logic top_bit_reg;
  logic top_bit_next;
  logic [CCW_PRIO_W:0] prio_reg;
  logic [CCW_PRIO_W:0] prio_next;
  logic [CCW_DATA_W-1:0] read_word;
  logic [CCW_DATA_W-1:0] wmask;
  logic [CCW_LVL_W-1:0] depth;
  logic loop_exit;
  logic hit;
  logic wr_take;
  logic exit_cond;

  // single register at one word address; every other address is a hole
  assign hit = (avs_address_i == CCW_CTRL_OFFSET);
  assign wr_take = (state_reg == CCW_BUS_ANSWER) && avs_write_i && hit;

  // handshake: the request is seen at one edge and answered at the next
  always_comb begin
    state_next = state_reg;
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    case (state_reg)
      CCW_BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          state_next = CCW_BUS_ANSWER;
          wait_next = 1'b0;
          rdata_next = hit ? read_word : '0; // holes read as zero
        end
      end
      CCW_BUS_ANSWER: begin
        state_next = CCW_BUS_IDLE;
      end
      default: begin
        state_next = CCW_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= CCW_BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // read image: stored bits, live depth, unused bits forced low
  always_comb begin
    read_word = ctrl_reg & CCW_CTRL_RW_MASK;
    read_word[CCW_UNUSED_LSB +: 3] = CCW_UNUSED_READ;
    read_word[CCW_BIT_EXIT] = exit_req_reg;
    read_word[CCW_LVL_LSB +: CCW_LVL_W] = depth;
    read_word[CCW_BIT_PRIO_TOP] = top_bit_reg;
  end

  // plain read/write bits follow the byte lanes; depth is never written
  always_comb begin
    wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}} & CCW_CTRL_RW_MASK;
    ctrl_next = ctrl_reg;
    if (wr_take) begin
      ctrl_next = (ctrl_reg & ~wmask) | (avs_writedata_i & wmask);
    end
  end

  // exit request: a one from software wins over its own retirement
  always_comb begin
    exit_req_next = exit_req_reg;
    // retire on the exit edge itself so a back-to-back iteration end cannot end a second loop
    if (exit_cond || depth == '0) exit_req_next = 1'b0;
    if (wr_take && avs_byteenable_i[1] && avs_writedata_i[CCW_BIT_EXIT]) begin
      exit_req_next = 1'b1; // writing zero leaves it alone
    end
  end

  // top priority bit: hardware sets, software clears by writing zero
  always_comb begin
    top_bit_next = top_bit_reg;
    if (wr_take && avs_byteenable_i[0] && !avs_writedata_i[CCW_BIT_PRIO_TOP]) begin
      top_bit_next = 1'b0;
    end
    if (priority_top_set_i) top_bit_next = 1'b1; // set wins over a clear
    prio_next = {top_bit_reg, cpu_status_word_i[CCW_PRIO_LSB +: CCW_PRIO_W]};
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_reg <= CCW_CTRL_RESET & CCW_CTRL_RW_MASK;
      exit_req_reg <= 1'b0;
      top_bit_reg <= 1'b0;
      prio_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      exit_req_reg <= exit_req_next;
      top_bit_reg <= top_bit_next;
      prio_reg <= prio_next;
    end
  end

  // nesting depth and early termination
  ccw_loop_track #(
    .LVL_W(CCW_LVL_W)
  ) u_loop (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(loop_start_i),
    .iter_end_i(iteration_end_i),
    .done_i(loop_done_i),
    .exit_req_i(exit_req_reg),
    .depth_o(depth),
    .exit_o(loop_exit)
  );

  // accumulator A: super or normal range chosen by the clamp mode bit
  ccw_clamp #(
    .IN_W(CCW_SUM_W),
    .WIDE_W(CCW_ACC_W),
    .NARROW_W(CCW_NARROW_W),
    .OUT_W(CCW_ACC_W),
    .OUT_LSB(0)
  ) u_clamp_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .value_i(acc_a_sum_i),
    .enable_i(ctrl_reg[CCW_BIT_CLAMP_A]),
    .wide_i(ctrl_reg[CCW_BIT_CLAMP_MODE]),
    .value_o(acc_a_o)
  );

  // accumulator B works the same way under its own enable
  ccw_clamp #(
    .IN_W(CCW_SUM_W),
    .WIDE_W(CCW_ACC_W),
    .NARROW_W(CCW_NARROW_W),
    .OUT_W(CCW_ACC_W),
    .OUT_LSB(0)
  ) u_clamp_b (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .value_i(acc_b_sum_i),
    .enable_i(ctrl_reg[CCW_BIT_CLAMP_B]),
    .wide_i(ctrl_reg[CCW_BIT_CLAMP_MODE]),
    .value_o(acc_b_o)
  );

  // stored word is the upper half of the 1.31 value, so clamp to 32 bits first
  ccw_clamp #(
    .IN_W(CCW_ACC_W),
    .WIDE_W(CCW_NARROW_W),
    .NARROW_W(CCW_NARROW_W),
    .OUT_W(CCW_DATA_W),
    .OUT_LSB(CCW_STORE_LSB)
  ) u_clamp_store (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .value_i(store_acc_i),
    .enable_i(ctrl_reg[CCW_BIT_STORE]),
    .wide_i(1'b0),
    .value_o(store_word_o)
  );

  // outputs, all taken from flops
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign loop_exit_o = loop_exit;
  assign loop_nest_level_o = depth;
  assign cpu_priority_level_o = prio_reg;
  assign multiply_sign_select_o = ctrl_reg[CCW_BIT_SIGN];
  assign int_mode_select_o = ctrl_reg[CCW_BIT_INT_MODE];
  assign round_mode_select_o = ctrl_reg[CCW_BIT_ROUND];
  assign program_view_enable_o = ctrl_reg[CCW_BIT_PROG_VIEW];

  assign exit_cond = exit_req_reg && iteration_end_i && (depth != '0);

  a_exit_after_iter: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (exit_cond && !loop_start_i)
      |=> loop_exit_o && (loop_nest_level_o != $past(loop_nest_level_o))
  ) else $error("early exit missing after iteration end");

  a_exit_zero_write: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_take && avs_byteenable_i[1] && !avs_writedata_i[CCW_BIT_EXIT] && !exit_req_reg)
      |=> !exit_req_reg ##1 !loop_exit_o
  ) else $error("writing zero to exit bit had an effect");

  a_depth_readback: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (avs_read_i && hit && !avs_waitrequest_o)
      |-> avs_readdata_o[CCW_LVL_LSB +: CCW_LVL_W] == $past(loop_nest_level_o)
  ) else $error("read depth differs from loop depth");

  a_depth_counts_up: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (loop_start_i && !loop_done_i && !exit_cond && loop_nest_level_o != 3'h7)
      |=> loop_nest_level_o == $past(loop_nest_level_o) + 3'h1
  ) else $error("loop depth did not count a new loop");

  a_priority_top_join: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    priority_top_set_i |=> ##1 cpu_priority_level_o[CCW_PRIO_W]
  ) else $error("top priority bit not joined into level");

  a_acc_a_clamped: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ctrl_reg[CCW_BIT_CLAMP_A] && !ctrl_reg[CCW_BIT_CLAMP_MODE] && !acc_a_sum_i[CCW_ACC_W]
      && acc_a_sum_i[CCW_ACC_W-1:CCW_NARROW_W-1] != '0) |=> acc_a_o == CCW_ACC_NARROW_MAX
  ) else $error("accumulator A overflow not clamped");

  a_acc_a_wraps: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (nrst_i && !ctrl_reg[CCW_BIT_CLAMP_A]) |=> acc_a_o == $past(acc_a_sum_i[CCW_ACC_W-1:0])
  ) else $error("accumulator A altered while clamp disabled");

  a_store_clamped: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (nrst_i && ctrl_reg[CCW_BIT_STORE] && store_acc_i[CCW_ACC_W-1]
      && store_acc_i[CCW_ACC_W-1:CCW_NARROW_W-1] != '1) |=> store_word_o == CCW_STORE_MIN
  ) else $error("negative store overflow not clamped");

  a_int_mode_write: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_take && avs_byteenable_i[0])
      |=> int_mode_select_o == $past(avs_writedata_i[CCW_BIT_INT_MODE])
  ) else $error("multiplier mode bit not written");

  a_unused_read_zero: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !avs_waitrequest_o |-> avs_readdata_o[CCW_UNUSED_LSB +: 3] == 3'h0
  ) else $error("unused bits did not read zero");

  a_depth_counts_down: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (loop_done_i && !loop_start_i && loop_nest_level_o != 3'h0)
      |=> loop_nest_level_o == $past(loop_nest_level_o) - 3'h1
  ) else $error("loop depth did not count a finished loop");

  a_depth_held_full: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (loop_start_i && !loop_done_i && !exit_cond && loop_nest_level_o == 3'h7)
      |=> loop_nest_level_o == 3'h7
  ) else $error("loop depth wrapped past seven");

  a_exit_request_done: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (exit_cond && !wr_take) |=> !exit_req_reg
  ) else $error("exit request outlived the loop it ended");

  a_top_set_wins: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (nrst_i && priority_top_set_i) |=> top_bit_reg
  ) else $error("top priority bit lost its hardware set");

  a_hole_read_zero: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (avs_read_i && !hit && !avs_waitrequest_o) |-> avs_readdata_o == '0
  ) else $error("unmapped read returned data");

  a_store_wraps: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (nrst_i && !ctrl_reg[CCW_BIT_STORE])
      |=> store_word_o == $past(store_acc_i[CCW_STORE_LSB +: CCW_DATA_W])
  ) else $error("stored word altered while clamp disabled");
endmodule

// *** tb/ccw_core_ctrl_tb.sv ***
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module ccw_core_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccw_pkg::*;

  logic clk = 1'b0, nrst = 1'b0;
  logic [CCW_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [CCW_DATA_W-1:0] avs_writedata = '0, avs_readdata, store_word, status = '0;
  logic [CCW_BE_W-1:0] avs_byteenable = '0;
  logic avs_waitrequest, loop_start = 1'b0, iter_end = 1'b0, loop_done = 1'b0, loop_exit;
  logic [CCW_LVL_W-1:0] nest_level;
  logic prio_set = 1'b0;
  logic [CCW_PRIO_W:0] prio_level;
  logic [CCW_SUM_W-1:0] sum_a = '0, sum_b = '0;
  logic [CCW_ACC_W-1:0] acc_a, acc_b, store_acc = '0;
  logic sign_sel, int_sel, round_sel, view_en;
  int fail_count = 0, num_checks = 0;
  // bench model of the control word
  logic [15:0] ctl = CCW_CTRL_RESET;
  logic top = 1'b0;
  logic [2:0] depth = 3'h0;
  logic [15:0] q;
  logic ex;

  always #20 clk = ~clk;

  ccw_core_ctrl u_ccw_core_ctrl (.clk_i(clk), .nrst_i(nrst), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .loop_start_i(loop_start),
    .iteration_end_i(iter_end), .loop_done_i(loop_done), .loop_exit_o(loop_exit),
    .loop_nest_level_o(nest_level), .priority_top_set_i(prio_set),
    .cpu_status_word_i(status), .cpu_priority_level_o(prio_level), .acc_a_sum_i(sum_a),
    .acc_a_o(acc_a), .acc_b_sum_i(sum_b), .acc_b_o(acc_b), .store_acc_i(store_acc),
    .store_word_o(store_word), .multiply_sign_select_o(sign_sel),
    .int_mode_select_o(int_sel), .round_mode_select_o(round_sel),
    .program_view_enable_o(view_en));

  // expected readback: writable bits from the model plus status fields
  function automatic logic [15:0] exp_word();
    return (ctl & CCW_CTRL_RW_MASK) | {5'h0, depth, 4'h0, top, 3'h0};
  endfunction

  // expected accumulator: wrap when disabled, else clamp to 40- or 32-bit range
  function automatic logic [39:0] exp_acc(input logic [40:0] s, input logic en, wide);
    if (!en) return s[39:0];
    if (wide) return (s[40] == s[39]) ? s[39:0] : (s[40] ? 40'h8000000000 : 40'h7fffffffff);
    if ($signed(s) > $signed(41'h007fffffff)) return 40'h007fffffff;
    if ($signed(s) < $signed(41'h1ff80000000)) return 40'hff80000000;
    return s[39:0];
  endfunction

  function automatic logic [15:0] exp_store(input logic [39:0] v, input logic en);
    if (en && $signed(v) > $signed(40'h007fffffff)) return 16'h7fff;
    if (en && $signed(v) < $signed(40'hff80000000)) return CCW_STORE_MIN;
    return v[31:16];
  endfunction

  // one bus transfer; request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d,
                      input logic [1:0] be, output logic [15:0] r);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] r, m;
    m = {{8{be[1]}}, {8{be[0]}}};
    xfer(1'b1, a, d, be, r);
    if (a == CCW_CTRL_OFFSET) begin
      ctl = (ctl & ~m) | (d & m);
      if (be[0] && !d[3]) top = 1'b0;
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    xfer(1'b0, a, 16'h0000, 2'h3, r);
  endtask

  // one-cycle loop pulses; exit pulse sampled in the cycle after they are seen
  task automatic pulse(input logic s, it, dn, output logic e);
    @(posedge clk);
    loop_start <= s;
    iter_end <= it;
    loop_done <= dn;
    @(posedge clk);
    loop_start <= 1'b0;
    iter_end <= 1'b0;
    loop_done <= 1'b0;
    @(negedge clk);
    e = loop_exit;
  endtask

  // drive the datapath for one cycle, check the registered results
  task automatic dp(input logic [40:0] a, b, input logic [39:0] s);
    @(posedge clk);
    sum_a <= a;
    sum_b <= b;
    store_acc <= s;
    @(posedge clk);
    @(negedge clk);
    `CHK(acc_a, exp_acc(a, ctl[CCW_BIT_CLAMP_A], ctl[CCW_BIT_CLAMP_MODE]))
    `CHK(acc_b, exp_acc(b, ctl[CCW_BIT_CLAMP_B], ctl[CCW_BIT_CLAMP_MODE]))
    `CHK(store_word, exp_store(s, ctl[CCW_BIT_STORE]))
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog sized well above the expected run of a few hundred cycles
  initial begin
    #(40 * 20000);
    fail_count++;
    conclude();
  end

  initial begin
    logic [63:0] t;
    logic [40:0] a, b;
    void'($urandom(50028));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(CCW_CTRL_OFFSET, q);
    `CHK(q, CCW_CTRL_RESET)
    `CHK({sign_sel, int_sel, round_sel, view_en}, 4'h0)
    $display("test reset done");
    // random writes, top bits and depth field must not take, exit bit kept clear
    for (int i = 0; i < 16; i++) begin
      wr(CCW_CTRL_OFFSET, 16'($urandom()) & 16'hf7ff, 2'($urandom()));
      rd(CCW_CTRL_OFFSET, q);
      `CHK(q, exp_word())
      `CHK({sign_sel, int_sel, round_sel, view_en}, {ctl[12], ctl[0], ctl[1], ctl[2]})
    end
    wr(4'h1, 16'hffff, 2'h3);
    rd(4'h1, q);
    `CHK(q, 16'h0000)
    rd(CCW_CTRL_OFFSET, q);
    `CHK(q, exp_word())
    $display("test register access done");
    // depth counts up, saturates at seven, software cannot write it
    for (int i = 0; i < 8; i++) begin
      pulse(1'b1, 1'b0, 1'b0, ex);
      if (depth != 3'h7) depth++;
      `CHK(nest_level, depth)
    end
    wr(CCW_CTRL_OFFSET, ctl & 16'hf0ff, 2'h3);
    rd(CCW_CTRL_OFFSET, q);
    `CHK(q, exp_word())
    for (int i = 0; i < 6; i++) begin
      pulse(1'b0, 1'b0, 1'b1, ex);
      depth--;
    end
    `CHK(nest_level, 3'h1)
    // zero in the exit bit does nothing, one ends the loop after this iteration
    pulse(1'b0, 1'b1, 1'b0, ex);
    `CHK(ex, 1'b0)
    wr(CCW_CTRL_OFFSET, ctl | 16'h0800, 2'h3);
    ctl[11] = 1'b0;
    pulse(1'b0, 1'b1, 1'b0, ex);
    depth = 3'h0;
    `CHK(ex, 1'b1)
    `CHK(nest_level, 3'h0)
    rd(CCW_CTRL_OFFSET, q);
    `CHK(q, exp_word())
    pulse(1'b0, 1'b0, 1'b1, ex);
    `CHK(nest_level, 3'h0)
    $display("test loop control done");
    // top priority bit joins status bits 7:5
    @(posedge clk);
    status <= 16'($urandom());
    prio_set <= 1'b1;
    @(posedge clk);
    prio_set <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    top = 1'b1;
    `CHK(prio_level, {1'b1, status[7:5]})
    rd(CCW_CTRL_OFFSET, q);
    `CHK(q, exp_word())
    wr(CCW_CTRL_OFFSET, ctl & 16'hfff7, 2'h1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(prio_level, {1'b0, status[7:5]})
    wr(CCW_CTRL_OFFSET, ctl | 16'h0008, 2'h1);
    rd(CCW_CTRL_OFFSET, q);
    `CHK(q, exp_word())
    $display("test priority done");
    // corner values then random sums under random clamp settings
    wr(CCW_CTRL_OFFSET, (ctl & 16'hff0f) | 16'h00e0, 2'h1);
    dp(41'h0080000000, 41'h1ff00000000, 40'h0100000000);
    dp(41'h1ff7fffffff, 41'h007fffffff, 40'hff00000000);
    wr(CCW_CTRL_OFFSET, (ctl & 16'hff0f) | 16'h0050, 2'h1);
    dp(41'h08000000000, 41'h17000000000, 40'h0100000000);
    for (int i = 0; i < 24; i++) begin
      wr(CCW_CTRL_OFFSET, (ctl & 16'hff0f) | (16'($urandom()) & 16'h00f0), 2'h1);
      t = {$urandom(), $urandom()};
      a = 41'(t >> (($urandom() % 4) * 8));
      b = 41'(t >> (($urandom() % 5) * 6));
      if ($urandom() % 2) a = ~a;
      dp(a, b, a[39:0]);
    end
    $display("test datapath done");
    // mid-run reset with a loop open and sums applied: all back to reset values
    pulse(1'b1, 1'b0, 1'b0, ex);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    ctl = CCW_CTRL_RESET;
    top = 1'b0;
    depth = 3'h0;
    `CHK({loop_exit, nest_level, prio_level}, 8'h00)
    `CHK({acc_a, store_word}, 56'h0)
    `CHK(avs_waitrequest, 1'b1)
    rd(CCW_CTRL_OFFSET, q);
    `CHK(q, exp_word())
    $display("test mid-run reset done");
    conclude();
  end
endmodule
